// ---- design/dsg_sync.sv ----
// Purpose: shared constants and types of the standby clock gating block,
//          plus the two-flop synchroniser for the debugger-present level
// Assumes: one system clock, asynchronous active-low reset
// Notes:   the package and the synchroniser share one file on purpose

// ----------------------------------------------------------------------------
// package
// ----------------------------------------------------------------------------
package dsg_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 4;

   // register map
   localparam logic [ADDR_W-1:0] STANDBY_CTRL_ADDR = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;

   // standby_control_register fields
   localparam int CTRL_SLEEP_BIT = 0;
   localparam int CTRL_HALT_BIT = 1;
   localparam int CTRL_HALT_FCO_BIT = 2;
   localparam int CTRL_DEEP_BIT = 3;
   localparam int CTRL_WDT_DEEP_BIT = 4;
   localparam int CTRL_W = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
   localparam logic [CTRL_W-1:0] CTRL_HALT_MASK = 5'h0e;

   // status register fields
   localparam int STAT_DBG_BIT = 0;
   localparam int STAT_STANDBY_BIT = 1;
   localparam int STAT_WAKING_BIT = 2;
   localparam int STAT_MODE_LSB = 4;

   // wake-up timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int DBG_WAKE_CYCLES = 4;
   localparam int HALT_WAKE_CYCLES = 8;
   localparam int FCO_WAKE_NS = 200000;
   localparam int DEEP_WAKE_NS = 800000;
   localparam int FCO_WAKE_CYCLES = FCO_WAKE_NS / CLK_PERIOD_NS;
   localparam int DEEP_WAKE_CYCLES = DEEP_WAKE_NS / CLK_PERIOD_NS;
   localparam int WAKE_CNT_W = 16;

   typedef enum logic [1:0] {
      mode_sleep,
      plain_halt_mode,
      halt_fast_clock_off_mode,
      deep_halt_modes
   } dsg_mode_type;

   typedef enum logic [1:0] {
      wake_clk_pll,
      wake_clk_low_speed_crystal,
      wake_clk_internal_rc
   } dsg_wake_clk_type;

   typedef enum logic [1:0] {
      st_run,
      st_standby,
      st_wake
   } dsg_state_type;
endpackage : dsg_pkg

// ----------------------------------------------------------------------------
// two-flop level synchroniser
// ----------------------------------------------------------------------------
module dsg_sync (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic level_in,
   output logic level_out
);
   logic stage1;

   // stage1 feeds only the second flop
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= 1'b0;
         level_out <= 1'b0;
      end else begin
         stage1 <= level_in;
         level_out <= stage1;
      end
   end
endmodule : dsg_sync

// ---- design/dsg_top.sv ----
// Purpose: standby clock gating that is aware of an attached debugger
// Assumes: register strobes and wake/break inputs synchronous to clock
// Notes:   all outputs registered; long wake counts are parameters
//
// Contract
// RULE_01 - debug break stops timer and watchdog clocks
// RULE_02 - with debugger, any halt entry becomes sleep
// RULE_03 - cpu clock stopped in every halt mode
// RULE_04 - fast clock stops only fco/deep without debugger
// RULE_05 - slow peripheral clock always runs
// RULE_06 - debugger forces halt request bits to zero
// RULE_07 - watchdog selectable only in deep, no debugger
// RULE_08 - debugger present: resume four cycles after wake
// RULE_09 - no debugger: 8 cycles, 200us, 800us
// RULE_10 - pll system: wake on crystal for fco/deep
// RULE_11 - rc system: always wake on rc oscillator
// RULE_12 - one synchronised registered debugger-present flag
//
// Local design decisions: the strobed register port and the register addresses.

module dsg_top #(
   parameter int unsigned WAKE_FCO_CYCLES = dsg_pkg::FCO_WAKE_CYCLES,
   parameter int unsigned WAKE_DEEP_CYCLES = dsg_pkg::DEEP_WAKE_CYCLES
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [dsg_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [dsg_pkg::DATA_W-1:0] reg_wr_data,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [dsg_pkg::DATA_W-1:0] reg_rd_data,
   input wire logic debugger_connected,
   input wire logic debug_break,
   input wire logic wake_irq,
   input wire logic sys_on_pll,
   output logic cpu_clock_enable,
   output logic fast_periph_clock_enable,
   output logic slow_periph_clock_enable,
   output logic timer_clock_enable,
   output logic watchdog_enable,
   output dsg_pkg::dsg_wake_clk_type wake_clock_select,
   output logic cpu_resume
);
   import dsg_pkg::*;

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   dsg_state_type state, next_state;
   dsg_mode_type mode, next_mode;
   logic [CTRL_W-1:0] ctrl, next_ctrl;
   logic [WAKE_CNT_W-1:0] wake_cnt, next_wake_cnt;
   logic entry_dbg, next_entry_dbg;
   logic entry_pll, next_entry_pll;
   logic dbg_present;
   logic [DATA_W-1:0] next_rd_data;

   // -------------------------------------------------------------------------
   // debugger presence
   // -------------------------------------------------------------------------
   dsg_sync u_dbg_sync (
      .clock(clock),
      .reset_n(reset_n),
      .level_in(debugger_connected),
      .level_out(dbg_present) // RULE_12
   );

   // -------------------------------------------------------------------------
   // functions
   // -------------------------------------------------------------------------
   function automatic dsg_mode_type req_mode(input logic [CTRL_W-1:0] req, input logic dbg);
      dsg_mode_type m;
      m = mode_sleep;
      if (dbg) begin
         m = mode_sleep; // RULE_02
      end else if (req[CTRL_DEEP_BIT]) begin
         m = deep_halt_modes;
      end else if (req[CTRL_HALT_FCO_BIT]) begin
         m = halt_fast_clock_off_mode;
      end else if (req[CTRL_HALT_BIT]) begin
         m = plain_halt_mode;
      end
      return m;
   endfunction : req_mode

   // true when the mode shuts the high-speed oscillator down
   function automatic logic deep_stop(input dsg_mode_type m, input logic dbg);
      return !dbg && (m == halt_fast_clock_off_mode || m == deep_halt_modes);
   endfunction : deep_stop

   function automatic logic [WAKE_CNT_W-1:0] wake_len(input dsg_mode_type m, input logic dbg);
      logic [WAKE_CNT_W-1:0] n;
      n = WAKE_CNT_W'(HALT_WAKE_CYCLES - 1); // RULE_09
      if (dbg) begin
         n = WAKE_CNT_W'(DBG_WAKE_CYCLES - 1); // RULE_08
      end else if (m == halt_fast_clock_off_mode) begin
         n = WAKE_CNT_W'(WAKE_FCO_CYCLES - 1); // RULE_09
      end else if (m == deep_halt_modes) begin
         n = WAKE_CNT_W'(WAKE_DEEP_CYCLES - 1); // RULE_09
      end
      return n;
   endfunction : wake_len

   // -------------------------------------------------------------------------
   // register decode
   // -------------------------------------------------------------------------
   wire ctrl_hit = (reg_addr == STANDBY_CTRL_ADDR);
   wire status_hit = (reg_addr == STATUS_ADDR);
   wire ctrl_wr = reg_wr && ctrl_hit && (state == st_run);
   wire [CTRL_W-1:0] wr_ctrl = reg_wr_data[CTRL_W-1:0];
   // any mode bit written requests entry, even a masked halt bit
   wire entry_req = ctrl_wr && (|wr_ctrl[CTRL_DEEP_BIT:CTRL_SLEEP_BIT]);
   wire take_wake = (state == st_standby) && wake_irq;
   wire wake_done = (state == st_wake) && (wake_cnt == '0);

   wire [DATA_W-1:0] status_word = {
      {(DATA_W-STAT_MODE_LSB-2){1'b0}},
      mode,
      1'b0,
      (state == st_wake),
      (state == st_standby),
      dbg_present
   };

   always_comb begin
      next_rd_data = '0;
      if (reg_rd && ctrl_hit) begin
         next_rd_data = {{(DATA_W-CTRL_W){1'b0}}, ctrl};
      end else if (reg_rd && status_hit) begin
         next_rd_data = status_word;
      end
   end

   // -------------------------------------------------------------------------
   // standby sequencing
   // -------------------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_mode = mode;
      next_wake_cnt = wake_cnt;
      next_entry_dbg = entry_dbg;
      next_entry_pll = entry_pll;
      next_ctrl = ctrl;
      if (ctrl_wr) begin
         next_ctrl = wr_ctrl;
      end
      if (dbg_present) begin
         next_ctrl = next_ctrl & ~CTRL_HALT_MASK; // RULE_06
      end
      case (state)
         st_run: begin
            if (entry_req) begin
               next_state = st_standby; // RULE_03
               next_mode = req_mode(wr_ctrl, dbg_present); // RULE_02
               next_entry_dbg = dbg_present;
               next_entry_pll = sys_on_pll;
            end
         end
         st_standby: begin
            if (take_wake) begin
               next_state = st_wake;
               next_wake_cnt = wake_len(mode, entry_dbg);
            end
         end
         st_wake: begin
            if (wake_done) begin
               next_state = st_run;
               next_ctrl = next_ctrl & ~CTRL_HALT_MASK & ~(CTRL_W'(1) << CTRL_SLEEP_BIT);
            end else begin
               next_wake_cnt = wake_cnt - WAKE_CNT_W'(1);
            end
         end
         default: begin
            next_state = st_run;
         end
      endcase
   end

   // -------------------------------------------------------------------------
   // output decode
   // -------------------------------------------------------------------------
   wire next_sb = (next_state != st_run);
   wire next_cpu_en = !next_sb; // RULE_03
   // oscillator stays down until the wait is over
   wire next_fast_en = !(next_sb && deep_stop(next_mode, next_entry_dbg)); // RULE_04
   wire wdt_off_deep = next_sb && !next_entry_dbg && (next_mode == deep_halt_modes)
                       && !next_ctrl[CTRL_WDT_DEEP_BIT]; // RULE_07
   wire next_timer_en = !debug_break; // RULE_01
   wire next_wdt_en = !debug_break && !wdt_off_deep; // RULE_01
   wire rc_wake = !next_entry_pll; // RULE_11
   wire xt_wake = next_entry_pll && deep_stop(next_mode, next_entry_dbg); // RULE_10

   dsg_wake_clk_type next_wake_clk;
   always_comb begin
      if (rc_wake) begin
         next_wake_clk = wake_clk_internal_rc; // RULE_11
      end else if (xt_wake) begin
         next_wake_clk = wake_clk_low_speed_crystal; // RULE_10
      end else begin
         next_wake_clk = wake_clk_pll; // RULE_10
      end
   end

   // -------------------------------------------------------------------------
   // flops
   // -------------------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= st_run;
         mode <= mode_sleep;
         ctrl <= CTRL_RESET;
         wake_cnt <= '0;
         entry_dbg <= 1'b0;
         entry_pll <= 1'b0;
      end else begin
         state <= next_state;
         mode <= next_mode;
         ctrl <= next_ctrl;
         wake_cnt <= next_wake_cnt;
         entry_dbg <= next_entry_dbg;
         entry_pll <= next_entry_pll;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reg_rd_data <= '0;
         cpu_clock_enable <= 1'b1;
         fast_periph_clock_enable <= 1'b1;
         slow_periph_clock_enable <= 1'b1;
         timer_clock_enable <= 1'b1;
         watchdog_enable <= 1'b1;
         wake_clock_select <= wake_clk_internal_rc;
         cpu_resume <= 1'b0;
      end else begin
         reg_rd_data <= next_rd_data;
         cpu_clock_enable <= next_cpu_en;
         fast_periph_clock_enable <= next_fast_en;
         slow_periph_clock_enable <= 1'b1; // RULE_05
         timer_clock_enable <= next_timer_en;
         watchdog_enable <= next_wdt_en;
         wake_clock_select <= next_wake_clk;
         cpu_resume <= wake_done;
      end
   end

   // -------------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------------
   // cycles spent waking, read only by the checks below
   logic [WAKE_CNT_W-1:0] wake_age;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wake_age <= '0;
      end else if (take_wake) begin
         wake_age <= '0;
      end else if (state == st_wake) begin
         wake_age <= wake_age + WAKE_CNT_W'(1);
      end
   end

   property p_break_gates;
      @(posedge clock) disable iff (!reset_n)
      debug_break |=> !timer_clock_enable && !watchdog_enable;
   endproperty
   a_break_gates: assert property (p_break_gates) else $error("break left clocks on"); // RULE_01

   property p_dbg_entry_sleep;
      @(posedge clock) disable iff (!reset_n)
      entry_req && dbg_present |=> state == st_standby && mode == mode_sleep;
   endproperty
   a_dbg_entry_sleep: assert property (p_dbg_entry_sleep) else $error("debug entry not sleep"); // RULE_02

   property p_cpu_stopped;
      @(posedge clock) disable iff (!reset_n)
      entry_req |=> !cpu_clock_enable throughout (state != st_run)[*2];
   endproperty
   a_cpu_stopped: assert property (p_cpu_stopped) else $error("cpu clock ran in standby"); // RULE_03

   property p_fast_clock;
      @(posedge clock) disable iff (!reset_n)
      state != st_run |-> fast_periph_clock_enable == !deep_stop(mode, entry_dbg);
   endproperty
   a_fast_clock: assert property (p_fast_clock) else $error("fast clock wrong in standby"); // RULE_04

   property p_slow_clock;
      @(posedge clock) disable iff (!reset_n)
      $past(entry_req) |-> slow_periph_clock_enable;
   endproperty
   a_slow_clock: assert property (p_slow_clock) else $error("slow clock stopped"); // RULE_05

   property p_halt_bits_low;
      @(posedge clock) disable iff (!reset_n)
      dbg_present |=> (ctrl & CTRL_HALT_MASK) == '0;
   endproperty
   a_halt_bits_low: assert property (p_halt_bits_low) else $error("halt bits set with debugger"); // RULE_06

   property p_wdt_runs;
      @(posedge clock) disable iff (!reset_n)
      state != st_run && mode != deep_halt_modes && !$past(debug_break) |-> watchdog_enable;
   endproperty
   a_wdt_runs: assert property (p_wdt_runs) else $error("watchdog stopped outside deep"); // RULE_07

   property p_dbg_wake4;
      @(posedge clock) disable iff (!reset_n)
      take_wake && entry_dbg |-> !cpu_clock_enable[*5] ##1 cpu_clock_enable && cpu_resume;
   endproperty
   a_dbg_wake4: assert property (p_dbg_wake4) else $error("debug wake not 4 cycles"); // RULE_08

   property p_halt_wake8;
      @(posedge clock) disable iff (!reset_n)
      take_wake && !entry_dbg && mode == plain_halt_mode |-> ##8 !cpu_clock_enable ##1 cpu_clock_enable;
   endproperty
   a_halt_wake8: assert property (p_halt_wake8) else $error("halt wake not 8 cycles"); // RULE_09

   property p_long_wake;
      @(posedge clock) disable iff (!reset_n)
      $rose(cpu_clock_enable) && !entry_dbg && deep_stop(mode, 1'b0) |->
         wake_age == ((mode == deep_halt_modes) ? WAKE_CNT_W'(WAKE_DEEP_CYCLES)
                                                : WAKE_CNT_W'(WAKE_FCO_CYCLES));
   endproperty
   a_long_wake: assert property (p_long_wake) else $error("long wake length wrong"); // RULE_09

   property p_wake_clock;
      @(posedge clock) disable iff (!reset_n)
      state == st_wake |-> wake_clock_select == (!entry_pll ? wake_clk_internal_rc :
         (deep_stop(mode, entry_dbg) ? wake_clk_low_speed_crystal : wake_clk_pll));
   endproperty
   a_wake_clock: assert property (p_wake_clock) else $error("wrong wake clock"); // RULE_10 RULE_11

   property p_dbg_sync;
      @(posedge clock) disable iff (!reset_n)
      $rose(dbg_present) |-> $past(debugger_connected, 2);
   endproperty
   a_dbg_sync: assert property (p_dbg_sync) else $error("debug flag not synchronised"); // RULE_12

   c_dbg_sleep: cover property (@(posedge clock) disable iff (!reset_n)
      take_wake && entry_dbg);
   c_deep_wake: cover property (@(posedge clock) disable iff (!reset_n)
      take_wake && !entry_dbg && mode == deep_halt_modes);
   c_halt_resume: cover property (@(posedge clock) disable iff (!reset_n)
      wake_done && mode == plain_halt_mode);
   c_break: cover property (@(posedge clock) disable iff (!reset_n)
      debug_break && state != st_run);
endmodule : dsg_top

// ---- test/dsg_core_model.sv ----
// Purpose: behavioural core and debug-probe side of the standby gating block
// Assumes: one system clock, asynchronous active-low reset
// Notes:   wake comes a set number of cycles after the cpu clock stops

// ----------------------------------------------------------------------------
// core and probe model
// ----------------------------------------------------------------------------
module dsg_core_model (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic cpu_clock_enable,
   input wire logic [7:0] wake_delay,
   input wire logic attach,
   input wire logic brk,
   output logic debugger_connected,
   output logic debug_break,
   output logic wake_irq
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] stop_count;

   // one pulse per standby stay; a longer delay models a slow interrupt source
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stop_count <= 16'h0000;
         wake_irq <= 1'b0;
         debugger_connected <= 1'b0;
         debug_break <= 1'b0;
      end else begin
         stop_count <= cpu_clock_enable ? 16'h0000 : stop_count + 16'h0001;
         wake_irq <= !cpu_clock_enable && (stop_count == {8'h00, wake_delay});
         debugger_connected <= attach;
         debug_break <= brk;
      end
   end
endmodule : dsg_core_model

// ---- test/dsg_top_test.sv ----
// Purpose: self-checking bench of the standby gating block
// Assumes: short wake counts set through the top parameters
// Notes:   expectations come from a small model function, never the design

module dsg_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   import dsg_pkg::*;

   localparam int FCO_N = 20;
   localparam int DEEP_N = 40;

   logic clock;
   logic reset_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sys_on_pll = 1'b0;
   logic attach = 1'b0;
   logic brk = 1'b0;
   logic [7:0] wake_delay = 8'h06;
   logic [ADDR_W-1:0] reg_addr = 4'h0;
   logic [DATA_W-1:0] reg_wr_data = 32'h0;
   logic [DATA_W-1:0] reg_rd_data;
   logic debugger_connected, debug_break, wake_irq, cpu_clock_enable, cpu_resume;
   logic fast_periph_clock_enable, slow_periph_clock_enable;
   logic timer_clock_enable, watchdog_enable;
   dsg_wake_clk_type wake_clock_select;
   int n_fail = 0;
   int total_checks = 0;
   // expected wake latencies, pushed at entry and popped at resume
   int exp_q[$];
   logic [31:0] seed = 32'h11;

   dsg_top #(.WAKE_FCO_CYCLES(FCO_N), .WAKE_DEEP_CYCLES(DEEP_N)) i_dsg_top (
      .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
      .debugger_connected(debugger_connected), .debug_break(debug_break),
      .wake_irq(wake_irq), .sys_on_pll(sys_on_pll), .cpu_clock_enable(cpu_clock_enable),
      .fast_periph_clock_enable(fast_periph_clock_enable),
      .slow_periph_clock_enable(slow_periph_clock_enable),
      .timer_clock_enable(timer_clock_enable), .watchdog_enable(watchdog_enable),
      .wake_clock_select(wake_clock_select), .cpu_resume(cpu_resume));

   dsg_core_model i_dsg_core_model (
      .clock(clock), .reset_n(reset_n), .cpu_clock_enable(cpu_clock_enable),
      .wake_delay(wake_delay), .attach(attach), .brk(brk),
      .debugger_connected(debugger_connected), .debug_break(debug_break),
      .wake_irq(wake_irq));

   // ----------------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : xorshift

   // wake latency that the model expects for a given debugger state and mode
   function automatic int model_latency(input int dbg, input int mode);
      if (dbg != 0) return DBG_WAKE_CYCLES;
      if (mode <= 1) return HALT_WAKE_CYCLES;
      return (mode == 2) ? FCO_N : DEEP_N;
   endfunction : model_latency

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wr_data <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      v = reg_rd_data;
   endtask : rd_reg

   // ----------------------------------------------------------------------------
   // clock and main sequence
   // ----------------------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   initial begin
      int d, p, m, k, i;
      logic [31:0] rd, val;
      logic wd;
      repeat (7) @(posedge clock);
      #1;
      check("reset_outs", 32'hfa, {24'h0, cpu_clock_enable, fast_periph_clock_enable,
         slow_periph_clock_enable, timer_clock_enable, watchdog_enable, cpu_resume,
         wake_clock_select});
      @(posedge clock);
      reset_n <= 1'b1;
      for (d = 0; d < 2; d++) begin
         @(posedge clock);
         attach <= d[0];
         repeat (4) @(posedge clock);
         rd_reg(STATUS_ADDR, rd);
         check("dbg_flag", d, rd[STAT_DBG_BIT]);
         for (p = 0; p < 2; p++) begin
            for (m = 0; m < 4; m++) begin
               seed = xorshift(seed);
               wd = seed[8];
               @(posedge clock);
               sys_on_pll <= p[0];
               wake_delay <= {6'h01, seed[1:0]};
               val = {seed[31:5], wd, 4'h0} | (32'h1 << m);
               wr_reg(STANDBY_CTRL_ADDR, val);
               exp_q.push_back(model_latency(d, m));
               #1;
               check("cpu_en", 0, cpu_clock_enable);
               check("fast_en", (d == 0 && m >= 2) ? 0 : 1, fast_periph_clock_enable);
               check("slow_en", 1, slow_periph_clock_enable);
               check("wdt_en", (d == 0 && m == 3 && !wd) ? 0 : 1, watchdog_enable);
               check("wake_clk", (p == 0) ? 2 : ((d == 0 && m >= 2) ? 1 : 0),
                  {30'h0, wake_clock_select});
               rd_reg(STATUS_ADDR, rd);
               check("mode", (d != 0) ? 0 : m, rd[STAT_MODE_LSB+:2]);
               check("standby", 1, rd[STAT_STANDBY_BIT]);
               rd_reg(STANDBY_CTRL_ADDR, rd);
               check("halt_bits", (d != 0) ? 0 : (val & CTRL_HALT_MASK), rd & CTRL_HALT_MASK);
               check("upper_bits", 0, rd >> CTRL_W);
               k = -1;
               for (i = 0; i < 200; i++) begin
                  @(posedge clock);
                  #1;
                  // irq launched at this edge is taken by the design at the next one
                  if (wake_irq === 1'b1 && k < 0) k = i + 1;
                  if (cpu_resume === 1'b1 || cpu_clock_enable === 1'b1) break;
               end
               if (i == 200 || k < 0) begin
                  n_fail++;
                  $display("[FAIL] wake expected resume seen none");
                  print_verdict();
               end
               check("latency", exp_q.pop_front(), i - k);
               check("resume_pair", 2'b11, {cpu_resume, cpu_clock_enable});
               rd_reg(STANDBY_CTRL_ADDR, rd);
               check("ctrl_clear", 0, rd[3:0]);
            end
         end
      end
      $display("test standby modes done");
      @(posedge clock);
      brk <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      check("brk_clocks", 0, {timer_clock_enable, watchdog_enable});
      @(posedge clock);
      brk <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      check("brk_release", 2'b11, {timer_clock_enable, watchdog_enable});
      $display("test debug break done");
      wr_reg(4'hc, 32'h0000000f);
      #1;
      check("unmapped_wr", 1, cpu_clock_enable);
      rd_reg(4'h8, rd);
      check("unmapped_rd", 0, rd);
      rd_reg(STATUS_ADDR, rd);
      check("status_dbg", 1, rd[STAT_DBG_BIT]);
      @(posedge clock);
      #1;
      check("rd_data_idle", 0, reg_rd_data);
      $display("test unmapped access done");
      print_verdict();
   end
endmodule : dsg_top_test
